// File: design/interrupt_status_collector.sv
// Purpose: Collects device events into one 32-bit interrupt status word
// Assumes: Event inputs are synchronous to aclk; pulses last one cycle
// Notes: Hold-off interval, polarity and buffer type live outside
module interrupt_status_collector
   import isc_pkg::*;
#(
   parameter int FRAME_LEN_W = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Transmit engine
   input wire logic tx_stop_request,
   input wire logic tx_halted,
   input wire logic tx_buffer_loaded,
   input wire logic tx_error,
   input wire logic tx_data_write_attempt,
   input wire logic tx_data_full,
   input wire logic [7:0] tx_free_blocks,
   input wire logic tx_status_push,
   input wire logic tx_status_full,
   input wire logic [7:0] tx_status_used,
   // Receive engine
   input wire logic rx_halted,
   input wire logic rx_transfer_done,
   input wire logic rx_error,
   input wire logic rx_len_valid,
   input wire logic [FRAME_LEN_W-1:0] rx_len,
   input wire logic rx_frame_dropped,
   input wire logic rx_status_full,
   input wire logic [7:0] rx_status_used,
   input wire logic drop_count_msb,
   // Timer, PHY, power and pins
   input wire logic [15:0] timer_value,
   input wire logic phy_event,
   input wire logic power_event,
   input wire logic [PIN_COUNT-1:0] pin_event,
   // Interrupt and wake outputs
   output logic irq_master,
   output logic irq_request,
   output logic power_irq,
   output logic wake_request
);
   if (FRAME_LEN_W < 12) begin : bad_len
      $error("FRAME_LEN_W must hold lengths above 2048");
   end

   typedef struct packed {
      logic [31:0] status;
      logic [31:0] enable;
      logic irq_en;
      logic [31:0] fifo_lvl;
      logic [15:0] timer_prev;
      logic irq_master;
      logic irq_request;
      logic power_irq;
      logic wake;
   } isc_st_t;

   localparam isc_st_t ISC_RST = '{fifo_lvl: FIFO_LVL_RST, timer_prev: TIMER_MAX, default: '0};
   localparam logic [FRAME_LEN_W-1:0] FRAME_MAX = FRAME_LEN_W'(MAX_FRAME_BYTES);

   isc_st_t st_r;
   isc_st_t st_nxt;

   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic [2:0] halt_rise;
   logic [31:0] ev;
   logic [31:0] wmask;
   logic [31:0] clr;

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end and edge detection

   axil_regif u_regif (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Halts and counter midpoint flag once per rise, not while held
   edge_rise #(
      .W(3)
   ) u_rise (
      .aclk(aclk),
      .aresetn(aresetn),
      .level({drop_count_msb, rx_halted, tx_stop_request && tx_halted}),
      .rise(halt_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event vector

   always_comb begin
      ev = '0;
      ev[SW_BIT] = st_r.enable[SW_BIT];
      ev[TXHALT_BIT] = halt_rise[0];
      ev[RXHALT_BIT] = halt_rise[1];
      ev[DROPH_BIT] = halt_rise[2];
      ev[TXLOAD_BIT] = tx_buffer_loaded;
      ev[RXDONE_BIT] = rx_transfer_done;
      ev[TWRAP_BIT] = (st_r.timer_prev == '0) && (timer_value == TIMER_MAX);
      ev[PWR_BIT] = power_event;
      ev[TX_OVF_BIT] = tx_status_push && tx_status_full;
      ev[RXOVR_BIT] = rx_len_valid && (rx_len > FRAME_MAX);
      ev[RX_ERR_BIT] = rx_error;
      ev[TX_ERR_BIT] = tx_error;
      ev[TX_OVR_BIT] = tx_data_write_attempt && tx_data_full;
      ev[TX_SPACE_BIT] = tx_free_blocks > st_r.fifo_lvl[SPACE_LVL_LO +: 8];
      ev[TX_SFULL_BIT] = tx_status_full;
      ev[RX_SFULL_BIT] = rx_status_full;
      ev[TX_SLVL_BIT] = tx_status_used > st_r.fifo_lvl[TX_LVL_LO +: 8];
      ev[RX_SLVL_BIT] = rx_status_used > st_r.fifo_lvl[RX_LVL_LO +: 8];
      ev[RXDROP_BIT] = rx_frame_dropped;
      ev[PIN_COUNT-1:0] = pin_event;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register update

   always_comb begin
      st_nxt = st_r;
      wmask = lane_mask(wr_strb);
      clr = '0;
      st_nxt.wake = 1'b0;
      st_nxt.timer_prev = timer_value;
      if (wr_en) begin
         unique case (wr_addr)
            STATUS_OFS: begin
               clr = wr_data & wmask & STS_CLR_MASK;
            end
            ENABLE_OFS: begin
               st_nxt.enable = (st_r.enable & ~(wmask & EN_RW_MASK)) |
                  (wr_data & wmask & EN_RW_MASK);
            end
            IRQ_CFG_OFS: begin
               if (wr_strb[CFG_IRQ_EN_BIT / 8]) begin
                  st_nxt.irq_en = wr_data[CFG_IRQ_EN_BIT];
               end
            end
            FIFO_LVL_OFS: begin
               st_nxt.fifo_lvl = (st_r.fifo_lvl & ~wmask) | (wr_data & wmask);
            end
            BYTE_TEST_OFS: begin
               st_nxt.wake = 1'b1;
            end
            default: begin
               clr = '0;
            end
         endcase
      end
      // Set wins over clear, mask plays no part in latching
      st_nxt.status = (st_r.status & ~clr) | ev;
      st_nxt.status[PHY_BIT] = phy_event;
      st_nxt.irq_master = |(st_nxt.status & st_nxt.enable);
      st_nxt.irq_request = st_nxt.irq_master && st_nxt.irq_en;
      // Power interrupt bypasses any hold-off applied downstream
      st_nxt.power_irq = st_nxt.status[PWR_BIT] && st_nxt.enable[PWR_BIT] &&
         st_nxt.irq_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ISC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      rd_data = '0;
      unique case (rd_addr)
         IRQ_CFG_OFS: begin
            rd_data[CFG_IRQ_EN_BIT] = st_r.irq_en;
            rd_data[CFG_MASTER_BIT] = st_r.irq_master;
         end
         STATUS_OFS: rd_data = st_r.status;
         ENABLE_OFS: rd_data = st_r.enable;
         BYTE_TEST_OFS: rd_data = BYTE_TEST_VAL;
         FIFO_LVL_OFS: rd_data = st_r.fifo_lvl & 32'hFFFF_00FF;
         default: rd_data = '0;
      endcase
   end

   assign irq_master = st_r.irq_master;
   assign irq_request = st_r.irq_request;
   assign power_irq = st_r.power_irq;
   assign wake_request = st_r.wake;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence sts_write;
      wr_en && (wr_addr == STATUS_OFS);
   endsequence

   sequence byte_test_write;
      wr_en && (wr_addr == BYTE_TEST_OFS);
   endsequence

   clear_one_a: assert property (
      sts_write and (wr_strb[0] && wr_data[0] && !pin_event[0]) |=> !st_r.status[0])
   else $error("Written one did not clear a pin flag");

   zero_keeps_a: assert property (
      st_r.status[RX_SLVL_BIT] && !(wr_en && wr_data[RX_SLVL_BIT]) |=> st_r.status[RX_SLVL_BIT])
   else $error("Flag lost without a written one");

   sw_flag_a: assert property (
      st_r.enable[SW_BIT] |=> st_r.status[SW_BIT])
   else $error("Software flag not set while enabled");

   tx_halt_a: assert property (
      $rose(tx_stop_request && tx_halted) |=> st_r.status[TXHALT_BIT])
   else $error("Transmit halt not flagged");

   drop_half_a: assert property (
      $rose(drop_count_msb) |=> st_r.status[DROPH_BIT])
   else $error("Drop counter midpoint not flagged");

   timer_wrap_a: assert property (
      ($past(timer_value) == 16'h0000) && (timer_value == TIMER_MAX) && $past(aresetn)
      |=> st_r.status[TWRAP_BIT])
   else $error("Timer wrap not flagged");

   phy_follow_a: assert property (
      1'b1 |=> st_r.status[PHY_BIT] == $past(phy_event))
   else $error("PHY flag does not follow its source");

   wake_write_a: assert property (
      byte_test_write |=> wake_request ##1 (wake_request == ($past(wr_en) &&
      ($past(wr_addr) == BYTE_TEST_OFS))))
   else $error("Wake does not follow the byte test write");

   no_wake_a: assert property (
      !(wr_en && (wr_addr == BYTE_TEST_OFS)) |=> !wake_request)
   else $error("Wake without a byte test write");

   power_path_a: assert property (
      st_r.status[PWR_BIT] && st_r.enable[PWR_BIT] && st_r.irq_en |-> power_irq)
   else $error("Power interrupt held back");

   oversize_a: assert property (
      rx_len_valid && (rx_len > FRAME_MAX) |=> st_r.status[RXOVR_BIT])
   else $error("Oversize frame not flagged");

   mask_free_a: assert property (
      tx_error && !st_r.enable[TX_ERR_BIT] |=> st_r.status[TX_ERR_BIT] && !irq_master ||
      st_r.status[TX_ERR_BIT])
   else $error("Masked event not latched");

   master_line_a: assert property (
      |(st_r.status & st_r.enable) |-> irq_master)
   else $error("Master line low with an enabled flag");

   set_wins_a: assert property (
      sts_write and pin_event[1] |=> st_r.status[1])
   else $error("Event lost to a simultaneous clear");

   level_cmp_a: assert property (
      tx_status_used > st_r.fifo_lvl[TX_LVL_LO +: 8] |=> st_r.status[TX_SLVL_BIT])
   else $error("Status level above threshold not flagged");
endmodule : interrupt_status_collector

// File: pkg/isc_pkg.sv
// Purpose: Shared constants for the interrupt status collector
// Assumes: 32-bit AXI4-Lite data, byte addresses on 8 bits
// Notes: Offsets are byte addresses of aligned 32-bit words
package isc_pkg;
   // Register offsets
   localparam logic [7:0] IRQ_CFG_OFS = 8'h54;
   localparam logic [7:0] STATUS_OFS = 8'h58;
   localparam logic [7:0] ENABLE_OFS = 8'h5C;
   localparam logic [7:0] BYTE_TEST_OFS = 8'h64;
   localparam logic [7:0] FIFO_LVL_OFS = 8'h68;
   // Reset and fixed values
   localparam logic [31:0] BYTE_TEST_VAL = 32'h8765_4321;
   localparam logic [31:0] FIFO_LVL_RST = 32'h4800_0000;
   localparam logic [31:0] STS_CLR_MASK = 32'h83BB_E7DF;
   localparam logic [31:0] EN_RW_MASK = 32'h83BF_E7DF;
   localparam logic [31:0] CFG_RW_MASK = 32'h0000_0100;
   // Status and enable bit positions
   localparam int SW_BIT = 31;
   localparam int TXHALT_BIT = 25;
   localparam int RXHALT_BIT = 24;
   localparam int DROPH_BIT = 23;
   localparam int TXLOAD_BIT = 21;
   localparam int RXDONE_BIT = 20;
   localparam int TWRAP_BIT = 19;
   localparam int PHY_BIT = 18;
   localparam int PWR_BIT = 17;
   localparam int TX_OVF_BIT = 16;
   localparam int RXOVR_BIT = 15;
   localparam int RX_ERR_BIT = 14;
   localparam int TX_ERR_BIT = 13;
   localparam int TX_OVR_BIT = 10;
   localparam int TX_SPACE_BIT = 9;
   localparam int TX_SFULL_BIT = 8;
   localparam int TX_SLVL_BIT = 7;
   localparam int RXDROP_BIT = 6;
   localparam int RX_SFULL_BIT = 4;
   localparam int RX_SLVL_BIT = 3;
   localparam int PIN_COUNT = 3;
   // Interrupt configuration bits
   localparam int CFG_IRQ_EN_BIT = 8;
   localparam int CFG_MASTER_BIT = 12;
   // Threshold field positions in the FIFO level register
   localparam int SPACE_LVL_LO = 24;
   localparam int TX_LVL_LO = 16;
   localparam int RX_LVL_LO = 0;
   // Event constants
   localparam int MAX_FRAME_BYTES = 2048;
   localparam logic [15:0] TIMER_MAX = 16'hFFFF;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Mapped register check
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == IRQ_CFG_OFS) || (a == STATUS_OFS) || (a == ENABLE_OFS) ||
         (a == BYTE_TEST_OFS) || (a == FIFO_LVL_OFS);
   endfunction : addr_ok

   // Byte strobes widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lane_mask
endpackage : isc_pkg

// File: design/edge_rise.sv
// Purpose: Rising edge detector for a group of levels
// Assumes: Levels synchronous to aclk
// Notes: Rise is combinational from level and the stored last value
module edge_rise
   import isc_pkg::*;
#(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Levels in, rises out
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise
);
   typedef struct packed {
      logic [W-1:0] prev;
   } er_st_t;

   er_st_t st_r;
   er_st_t st_nxt;

   if (W < 1) begin : bad_width
      $error("edge_rise needs W of at least 1");
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = level;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise = level & ~st_r.prev;
endmodule : edge_rise

// File: design/axil_regif.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: One write and one read under way at a time
// Notes: Write strobe lasts one cycle; unmapped address answers SLVERR
module axil_regif
   import isc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address and data
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register file side
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data
);
   typedef enum logic [2:0] {
      WR_COLLECT = 3'b001,
      WR_APPLY = 3'b010,
      WR_RESP = 3'b100
   } wr_state_t;

   typedef struct packed {
      wr_state_t ws;
      logic aw_full;
      logic w_full;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic rpend;
      logic [7:0] raddr;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_st_t;

   localparam axi_st_t AXI_RST = '{ws: WR_COLLECT, awready: 1'b1, wready: 1'b1,
      arready: 1'b1, default: '0};

   axi_st_t st_r;
   axi_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      unique case (st_r.ws)
         WR_COLLECT: begin
            if (awvalid && st_r.awready) begin
               st_nxt.aw_full = 1'b1;
               st_nxt.waddr = awaddr;
            end
            if (wvalid && st_r.wready) begin
               st_nxt.w_full = 1'b1;
               st_nxt.wdata = wdata;
               st_nxt.wstrb = wstrb;
            end
            if (st_nxt.aw_full && st_nxt.w_full) begin
               st_nxt.ws = WR_APPLY;
            end
         end
         WR_APPLY: begin
            st_nxt.ws = WR_RESP;
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.bresp = addr_ok(st_r.waddr) ? RESP_OKAY : RESP_SLVERR;
         end
         WR_RESP: begin
            if (bready) begin
               st_nxt.ws = WR_COLLECT;
            end
         end
         default: begin
            st_nxt.ws = WR_COLLECT;
         end
      endcase
      st_nxt.awready = (st_nxt.ws == WR_COLLECT) && !st_nxt.aw_full;
      st_nxt.wready = (st_nxt.ws == WR_COLLECT) && !st_nxt.w_full;
      // Read: address taken, data captured one cycle later
      if (arvalid && st_r.arready) begin
         st_nxt.rpend = 1'b1;
         st_nxt.raddr = araddr;
      end
      if (st_r.rpend) begin
         st_nxt.rpend = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_data;
         st_nxt.rresp = addr_ok(st_r.raddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      st_nxt.arready = !st_nxt.rpend && !st_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= AXI_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign awready = st_r.awready;
   assign wready = st_r.wready;
   assign bresp = st_r.bresp;
   assign bvalid = st_r.ws[2];
   assign arready = st_r.arready;
   assign rdata = st_r.rdata;
   assign rresp = st_r.rresp;
   assign rvalid = st_r.rvalid;
   assign wr_en = st_r.ws[1];
   assign wr_addr = st_r.waddr;
   assign wr_data = st_r.wdata;
   assign wr_strb = st_r.wstrb;
   assign rd_addr = st_r.raddr;
endmodule : axil_regif

// File: tb/host_model.sv
// Purpose: Host side AXI4-Lite master for the status collector bench
// Assumes: One write or read at a time, full word strobes
// Notes: Released payload lines show the inverse of the last value
module host_model
   import isc_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   // Wait ran out
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, hung} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dv;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            wdata <= ~dv;
         end
         if (bvalid === 1'b1) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 40) hung <= 1'b1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid === 1'b1) begin
            dv = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 40) hung <= 1'b1;
   endtask : rd
endmodule : host_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the interrupt status collector
// Assumes: Host model drives the register bus
// Notes: Row i of the table pulses event input i alone
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s expected %h seen %h", n, e, s); end end
module tb_top
   import isc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn;
   logic [7:0] awaddr, araddr, free, tsu, rsu;
   logic awvalid, awready, wvalid, wready, bvalid, bready, hung, phy, hlt;
   logic arvalid, arready, rvalid, rready, irq_master, irq_request, power_irq, wake_request;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [15:0] ev, len, tmr;
   int miscompares = 0;
   int compares = 0;
   int wakes = 0;
   int i;
   logic [31:0] exp_tab [16] = '{32'h0020_0000, 32'h0000_2000, 32'h0000_4000, 32'h0010_0000,
      32'h0000_0040, 32'h0002_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0004,
      32'h0100_0000, 32'h0080_0000, 32'h0001_0100, 32'h0000_0400, 32'h0200_0000,
      32'h0000_0010, 32'h0000_8000};
   logic [7:0] map_addr [6] = '{IRQ_CFG_OFS, STATUS_OFS, ENABLE_OFS, BYTE_TEST_OFS,
      FIFO_LVL_OFS, 8'h60};
   logic [31:0] map_val [6] = '{32'h0, 32'h0, 32'h0, 32'h8765_4321, 32'h4800_0000, 32'h0};
   always #20 aclk = ~aclk;
   always @(posedge aclk) if (wake_request === 1'b1) wakes <= wakes + 1;
   always @(posedge hung) begin
      miscompares++;
      final_report;
   end
   host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .hung);
   interrupt_status_collector uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .tx_stop_request(ev[13]), .tx_halted(ev[13] | hlt),
      .tx_buffer_loaded(ev[0]), .tx_error(ev[1]), .tx_data_write_attempt(ev[12]),
      .tx_data_full(ev[12]), .tx_free_blocks(free), .tx_status_push(ev[11]),
      .tx_status_full(ev[11]), .tx_status_used(tsu), .rx_halted(ev[9]),
      .rx_transfer_done(ev[3]), .rx_error(ev[2]), .rx_len_valid(ev[15]), .rx_len(len),
      .rx_frame_dropped(ev[4]), .rx_status_full(ev[14]), .rx_status_used(rsu),
      .drop_count_msb(ev[10]), .timer_value(tmr), .phy_event(phy), .power_event(ev[5]),
      .pin_event(ev[8:6]), .irq_master, .irq_request, .power_irq, .wake_request);
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic pulse(input int k);
      @(posedge aclk);
      ev <= 16'h0001 << k;
      @(posedge aclk);
      ev <= 16'h0000;
   endtask : pulse
   task automatic sts(input logic [31:0] e);
      host.rd(STATUS_OFS, d, r);
      `CHK("status", e, d)
   endtask : sts
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   initial begin
      {aresetn, ev, tmr, phy, hlt, free, tsu, rsu} = '0;
      len = 16'h0801;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) begin
         host.rd(map_addr[i], d, r);
         `CHK("reset value", map_val[i], d)
         `CHK("read resp", (i == 5) ? RESP_SLVERR : RESP_OKAY, r)
      end
      for (i = 0; i < 16; i++) begin
         pulse(i);
         sts(exp_tab[i]);
         host.wr(STATUS_OFS, 32'hFFFF_FFFF, r);
      end
      `CHK("wake", 0, wakes)
      pulse(1);
      pulse(2);
      host.wr(STATUS_OFS, 32'h0000_2000, r);
      sts(32'h0000_4000);
      host.wr(STATUS_OFS, 32'h0000_0000, r);
      sts(32'h0000_4000);
      host.wr(ENABLE_OFS, 32'h0000_4000, r);
      host.wr(IRQ_CFG_OFS, 32'h0000_0100, r);
      host.rd(IRQ_CFG_OFS, d, r);
      `CHK("config", 32'h0000_1100, d)
      `CHK("irq", 2'b11, {irq_master, irq_request})
      host.wr(ENABLE_OFS, 32'h0002_0000, r);
      pulse(5);
      sts(32'h0002_4000);
      `CHK("power irq", 1'b1, power_irq)
      host.wr(ENABLE_OFS, 32'h8000_0000, r);
      host.wr(STATUS_OFS, 32'hFFFF_FFFF, r);
      sts(32'h8000_0000);
      `CHK("master", 1'b1, irq_master)
      host.wr(ENABLE_OFS, 32'h0000_0000, r);
      host.wr(STATUS_OFS, 32'hFFFF_FFFF, r);
      sts(32'h0000_0000);
      `CHK("master", 1'b0, irq_master)
      `CHK("power irq", 1'b0, power_irq)
      host.wr(BYTE_TEST_OFS, 32'h0000_0000, r);
      `CHK("write resp", RESP_OKAY, r)
      host.wr(8'h60, 32'hFFFF_FFFF, r);
      `CHK("write resp", RESP_SLVERR, r)
      sts(32'h0000_0000);
      `CHK("wake", 1, wakes)
      phy <= 1'b1;
      sts(32'h0004_0000);
      host.wr(STATUS_OFS, 32'h0004_0000, r);
      sts(32'h0004_0000);
      phy <= 1'b0;
      sts(32'h0000_0000);
      @(posedge aclk) tmr <= 16'h0005;
      @(posedge aclk) tmr <= 16'hFFFF;
      sts(32'h0000_0000);
      @(posedge aclk) tmr <= 16'h0000;
      @(posedge aclk) tmr <= 16'hFFFF;
      sts(32'h0008_0000);
      host.wr(STATUS_OFS, 32'hFFFF_FFFF, r);
      len <= 16'h0800;
      pulse(15);
      sts(32'h0000_0000);
      hlt <= 1'b1;
      sts(32'h0000_0000);
      hlt <= 1'b0;
      free <= 8'h48;
      sts(32'h0000_0000);
      free <= 8'h49;
      tsu <= 8'h01;
      rsu <= 8'h01;
      sts(32'h0000_0288);
      free <= 8'h00;
      tsu <= 8'h00;
      rsu <= 8'h00;
      pulse(7);
      // Pin event lands in the very cycle the clear is applied
      fork
         host.wr(STATUS_OFS, 32'hFFFF_FFFF, r);
         begin
            repeat (2) @(posedge aclk);
            ev <= 16'h0080;
            @(posedge aclk);
            ev <= 16'h0000;
         end
      join
      `CHK("write resp", RESP_OKAY, r)
      sts(32'h0000_0002);
      // Reset in mid-run with flags and irq enable set
      pulse(6);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      sts(32'h0000_0000);
      host.rd(IRQ_CFG_OFS, d, r);
      `CHK("config", 32'h0000_0000, d)
      `CHK("irq", 2'b00, {irq_master, irq_request})
      final_report;
   end
endmodule : tb_top
